// *** src/mmc_regs.v ***
// upper configuration register bank of the hardware monitor: intrusion clear, vid, address, temp irq
`timescale 1ns/1ps
`include "mmc_consts.vh"

module mmc_regs #(
   parameter integer CI_CNT_W     = `MMC_CI_CNT_W,
   parameter integer CI_CYCLES    = `MMC_CI_PULSE_CYCLES,
   // arbitrary neutral power-up value of the ident bits 7..1
   parameter [6:0]   ID_RESET     = `MMC_ID_RESET
) (
   input  wire       clk,
   input  wire       rst_b,
   input  wire [7:0] reg_addr,
   input  wire       reg_wr,
   input  wire       reg_rd,
   input  wire [7:0] reg_wdata,
   output reg  [7:0] reg_rdata,
   output reg        reg_rd_valid,
   input  wire [3:0] voltage_id_bits,
   input  wire       voltage_id_top_bit,
   input  wire       addr_select_pin_lo,
   input  wire       addr_select_pin_hi,
   input  wire       conv_done,
   input  wire [8:0] temp_value,
   input  wire [7:0] hot_limit,
   input  wire [7:0] hyst_limit,
   input  wire       temp_irq_mask,
   output reg        temp_status,
   output reg        temp_irq_n,
   output reg        intrusion_pulse_n,
   output reg  [1:0] first_fan_prescale,
   output reg  [1:0] second_fan_prescale,
   output reg  [3:0] first_fan_ratio,
   output reg  [3:0] second_fan_ratio,
   output reg  [6:0] bus_address
);

   // prescale select to divide ratio; 00 by 1 up to 11 by 8
   function [3:0] fan_ratio;
      input [1:0] sel;
      begin
         case (sel)
            2'h0:    fan_ratio = 4'h1;
            2'h1:    fan_ratio = 4'h2;
            2'h2:    fan_ratio = 4'h4;
            default: fan_ratio = 4'h8;
         endcase
      end
   endfunction

   // ---------------- pin synchronisers ----------------
   // pins: vid[3:0], top vid, addr lo, addr hi
   wire [6:0] pin_raw = {addr_select_pin_hi, addr_select_pin_lo, voltage_id_top_bit,
                         voltage_id_bits};
   reg  [6:0] pin_s1;
   reg  [6:0] pin_s2;
   reg  [6:0] pin_s3;
   reg  [6:0] pin_filt;

   // a change is taken only when stage two and three agree, so one-cycle glitches never land
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pin_s1   <= 7'h00;
         pin_s2   <= 7'h00;
         pin_s3   <= 7'h00;
         pin_filt <= 7'h00;
      end else begin
         pin_s1   <= pin_raw;
         pin_s2   <= pin_s1;
         pin_s3   <= pin_s2;
         pin_filt <= (pin_s2 & pin_s3) | (pin_filt & (pin_s2 | pin_s3));
      end
   end

   // ---------------- register write decode ----------------
   wire wr_compat = reg_wr && (reg_addr == `MMC_ADDR_COMPAT);
   wire wr_intr   = reg_wr && (reg_addr == `MMC_ADDR_INTR_CLR);
   wire wr_vidfan = reg_wr && (reg_addr == `MMC_ADDR_VID_FAN);
   wire wr_busadr = reg_wr && (reg_addr == `MMC_ADDR_BUS_ADDR);
   wire wr_ident  = reg_wr && (reg_addr == `MMC_ADDR_VID_IDENT);
   wire wr_tcfg   = reg_wr && (reg_addr == `MMC_ADDR_TEMP_CFG);
   wire rd_status = reg_rd && (reg_addr == `MMC_ADDR_STATUS1);

   reg [7:0] compat_placeholder;
   reg [6:0] intr_low_bits;
   reg       intr_clear_bit;
   reg [6:0] ident_bits;
   reg [1:0] temp_mode;
   reg [4:0] temp_rsvd;
   reg       temp_half_deg;
   reg [2:0] seed_cnt;
   reg       seeded;

   // ---------------- chassis intrusion pulse ----------------
   wire ci_pulse_n;
   wire ci_done;
   // bit 7 doubles as the busy flag, so a second one during a pulse cannot restart it
   wire ci_start = wr_intr && reg_wdata[`MMC_INTR_CLR_BIT] && !intr_clear_bit;

   mmc_pulse_timer #(
      .CNT_W  (CI_CNT_W),
      .CYCLES (CI_CYCLES)
   ) u_ci_timer (
      .clk     (clk),
      .rst_b   (rst_b),
      .start   (ci_start),
      .pulse_n (ci_pulse_n),
      .done    (ci_done)
   );

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         intrusion_pulse_n <= 1'b1;
         intr_clear_bit    <= 1'b0;
         intr_low_bits     <= `MMC_INTR_RESET;
      end else begin
         intrusion_pulse_n <= ci_pulse_n;
         if (ci_start)
            intr_clear_bit <= 1'b1;
         else if (ci_done)
            intr_clear_bit <= 1'b0;
         if (wr_intr)
            intr_low_bits <= reg_wdata[6:0];
      end
   end

   // ---------------- plain configuration storage ----------------
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         compat_placeholder  <= `MMC_COMPAT_RESET;
         first_fan_prescale  <= `MMC_FAN_PRE_RESET;
         second_fan_prescale <= `MMC_FAN_PRE_RESET;
         first_fan_ratio     <= `MMC_FAN_RATIO_RESET;
         second_fan_ratio    <= `MMC_FAN_RATIO_RESET;
         ident_bits          <= ID_RESET;
         temp_mode           <= `MMC_TEMP_MODE_RESET;
         temp_rsvd           <= `MMC_TEMP_RSVD_RESET;
      end else begin
         if (wr_compat)
            compat_placeholder <= reg_wdata;
         if (wr_vidfan) begin
            first_fan_prescale  <= reg_wdata[`MMC_FAN1_LO+1:`MMC_FAN1_LO];
            second_fan_prescale <= reg_wdata[`MMC_FAN2_LO+1:`MMC_FAN2_LO];
         end
         first_fan_ratio  <= fan_ratio(first_fan_prescale);
         second_fan_ratio <= fan_ratio(second_fan_prescale);
         if (wr_ident)
            ident_bits <= reg_wdata[7:1];
         if (wr_tcfg) begin
            temp_mode <= reg_wdata[1:0];
            temp_rsvd <= reg_wdata[6:2];
         end
      end
   end

   // ---------------- bus address with pin seeding ----------------
   // the address pins are caught only after the synchroniser has settled past reset release
   // a write before the seed lands is dropped, as the seed would overwrite it anyway
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         bus_address <= {`MMC_BUS_ADDR_TOP, 2'h0};
         seed_cnt    <= 3'h0;
         seeded      <= 1'b0;
      end else begin
         if (!seeded) begin
            if (seed_cnt == `MMC_SEED_WAIT) begin
               seeded      <= 1'b1;
               bus_address <= {`MMC_BUS_ADDR_TOP, pin_filt[6:5]};
            end else begin
               seed_cnt <= seed_cnt + 3'h1;
            end
         end else if (wr_busadr) begin
            bus_address <= reg_wdata[6:0];
         end
      end
   end

   // ---------------- temperature interrupt ----------------
   // a reading equal to a limit is neither above hot nor below hysteresis
   // only whole degrees are compared; the half-degree bit is shown, never judged
   wire signed [7:0] temp_whole = temp_value[8:1];
   wire signed [7:0] hot_s      = hot_limit;
   wire signed [7:0] hyst_s     = hyst_limit;
   wire              above_hot  = temp_whole > hot_s;
   wire              below_hyst = temp_whole < hyst_s;
   wire              mode_once  = (temp_mode == `MMC_MODE_ONCE);
   wire              mode_comp  = (temp_mode == `MMC_MODE_COMP);

   reg  over_armed;
   reg  once_fired;
   reg  next_over_armed;
   reg  next_once_fired;
   reg  temp_set;
   reg  next_status;

   always @* begin
      next_over_armed = over_armed;
      next_once_fired = once_fired;
      temp_set        = 1'b0;
      if (conv_done) begin
         if (above_hot)
            next_over_armed = 1'b1;
         else if (below_hyst)
            next_over_armed = 1'b0;
         if (below_hyst)
            next_once_fired = 1'b0;
         if (mode_once) begin
            if (above_hot && !once_fired) begin
               temp_set        = 1'b1;
               next_once_fired = 1'b1;
            end
         end else if (!mode_comp) begin
            temp_set = next_over_armed;
         end
      end
   end

   // comparator mode tracks the limit directly and a status read does not drop it
   always @* begin
      next_status = temp_status;
      if (mode_comp) begin
         if (conv_done)
            next_status = above_hot;
      end else if (temp_set) begin
         next_status = 1'b1; // set wins over a read in the same cycle
      end else if (rd_status) begin
         next_status = 1'b0;
      end
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         over_armed    <= 1'b0;
         once_fired    <= 1'b0;
         temp_status   <= 1'b0;
         temp_irq_n    <= 1'b1;
         temp_half_deg <= 1'b0;
      end else begin
         over_armed  <= next_over_armed;
         once_fired  <= next_once_fired;
         temp_status <= next_status;
         temp_irq_n  <= ~(next_status & ~temp_irq_mask);
         if (conv_done)
            temp_half_deg <= temp_value[0];
      end
   end

   // ---------------- read path ----------------
   // the status byte carries only the temp bit; the other sources are merged outside
   reg [7:0] rd_mux;

   always @* begin
      case (reg_addr)
         `MMC_ADDR_STATUS1:
            rd_mux = {3'h0, temp_status, 4'h0};
         `MMC_ADDR_COMPAT:
            rd_mux = compat_placeholder;
         `MMC_ADDR_INTR_CLR:
            rd_mux = {intr_clear_bit, intr_low_bits};
         `MMC_ADDR_VID_FAN:
            rd_mux = {second_fan_prescale, first_fan_prescale, pin_filt[3:0]};
         `MMC_ADDR_BUS_ADDR:
            rd_mux = {1'b0, bus_address};
         `MMC_ADDR_VID_IDENT:
            rd_mux = {ident_bits, pin_filt[4]};
         `MMC_ADDR_TEMP_CFG:
            rd_mux = {temp_half_deg, temp_rsvd, temp_mode};
         default:
            rd_mux = 8'h00;
      endcase
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata    <= 8'h00;
         reg_rd_valid <= 1'b0;
      end else begin
         reg_rd_valid <= reg_rd;
         if (reg_rd)
            reg_rdata <= rd_mux;
      end
   end

endmodule // mmc_regs

// *** src/mmc_consts.vh ***
// register offsets, field positions, reset values and timing figures of the misc config bank
`ifndef MMC_CONSTS_VH
`define MMC_CONSTS_VH

`define MMC_ADDR_STATUS1      8'h41
`define MMC_ADDR_COMPAT       8'h45
`define MMC_ADDR_INTR_CLR     8'h46
`define MMC_ADDR_VID_FAN      8'h47
`define MMC_ADDR_BUS_ADDR     8'h48
`define MMC_ADDR_VID_IDENT    8'h49
`define MMC_ADDR_TEMP_CFG     8'h4B

`define MMC_STATUS1_TEMP_BIT  4
`define MMC_INTR_CLR_BIT      7
`define MMC_FAN1_LO           4
`define MMC_FAN2_LO           6
`define MMC_TEMP_LSB_BIT      7

`define MMC_COMPAT_RESET      8'h00
`define MMC_INTR_RESET        7'h00
`define MMC_FAN_PRE_RESET     2'h1
`define MMC_BUS_ADDR_TOP      5'h0B
`define MMC_TEMP_MODE_RESET   2'h1
`define MMC_TEMP_RSVD_RESET   5'h00
`define MMC_ID_RESET          7'h15 // arbitrary neutral value of the ident bits
`define MMC_FAN_RATIO_RESET   4'h2

`define MMC_MODE_DEF0         2'h0
`define MMC_MODE_ONCE         2'h1
`define MMC_MODE_COMP         2'h2
`define MMC_MODE_DEF3         2'h3

`define MMC_CLK_KHZ           200000
`define MMC_CI_PULSE_MS       20
`define MMC_CI_PULSE_CYCLES   (`MMC_CI_PULSE_MS * `MMC_CLK_KHZ)
`define MMC_CI_CNT_W          23
`define MMC_SEED_WAIT         3'h4

`endif

// *** src/mmc_pulse_timer.v ***
// one-shot low pulse generator for the chassis intrusion pin
`timescale 1ns/1ps
`include "mmc_consts.vh"

module mmc_pulse_timer #(
   parameter integer CNT_W  = `MMC_CI_CNT_W,
   parameter integer CYCLES = `MMC_CI_PULSE_CYCLES
) (
   input  wire             clk,
   input  wire             rst_b,
   input  wire             start,
   output reg              pulse_n,
   output reg              done
);

   localparam [31:0]      LAST_W = CYCLES - 1;
   localparam [CNT_W-1:0] LAST   = LAST_W[CNT_W-1:0];

   reg [CNT_W-1:0] count;

   // start is ignored while a pulse runs; the pulse is never stretched
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pulse_n <= 1'b1;
         done    <= 1'b0;
         count   <= {CNT_W{1'b0}};
      end else begin
         done <= 1'b0;
         if (pulse_n) begin
            if (start) begin
               pulse_n <= 1'b0;
               count   <= {CNT_W{1'b0}};
            end
         end else if (count == LAST) begin
            pulse_n <= 1'b1;
            done    <= 1'b1;
         end else begin
            count <= count + {{(CNT_W-1){1'b0}}, 1'b1};
         end
      end
   end

endmodule // mmc_pulse_timer

// *** dv/mmc_host_model.sv ***
// host side model that drives the register strobe port
`timescale 1ns/1ps
module mmc_host_model (
   input  wire        clk,
   output logic [7:0] reg_addr,
   output logic       reg_wr,
   output logic       reg_rd,
   output logic [7:0] reg_wdata,
   input  wire  [7:0] reg_rdata,
   input  wire        reg_rd_valid
);
   initial begin
      reg_addr = 8'h00;
      reg_wr = 1'h0;
      reg_rd = 1'h0;
      reg_wdata = 8'h00;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'h1;
      @(negedge clk);
      reg_wr = 1'h0;
      // data no longer qualified, so it must not keep showing the old byte
      reg_wdata = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output bit to);
      int i;
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1'h1;
      @(negedge clk);
      reg_rd = 1'h0;
      for (i = 0; i < 4 && reg_rd_valid !== 1'h1; i++) @(negedge clk);
      to = (reg_rd_valid !== 1'h1);
      d = reg_rdata;
   endtask
endmodule // mmc_host_model

// *** dv/mmc_regs_checker.sv ***
// port-level assertions for the misc config register bank
`timescale 1ns/1ps
`include "mmc_consts.vh"
module mmc_regs_checker #(
   parameter integer CI_CYCLES = `MMC_CI_PULSE_CYCLES
) (
   input wire       clk,
   input wire       rst_b,
   input wire [7:0] reg_addr,
   input wire       reg_wr,
   input wire       reg_rd,
   input wire [7:0] reg_wdata,
   input wire [7:0] reg_rdata,
   input wire       reg_rd_valid,
   input wire       conv_done,
   input wire       temp_irq_mask,
   input wire       temp_status,
   input wire       temp_irq_n,
   input wire       intrusion_pulse_n,
   input wire [1:0] first_fan_prescale,
   input wire [1:0] second_fan_prescale,
   input wire [3:0] first_fan_ratio,
   input wire [3:0] second_fan_ratio
);
   int low_cnt;
   wire clr_wr = reg_wr && reg_addr == `MMC_ADDR_INTR_CLR && reg_wdata[7];
   always @(posedge clk or negedge rst_b)
      if (!rst_b) low_cnt <= 0;
      else low_cnt <= intrusion_pulse_n ? 0 : low_cnt + 1;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   pulse_len_a: assert property ($rose(intrusion_pulse_n) |-> low_cnt >= CI_CYCLES)
      else $error("intrusion pulse too short");
   pulse_cause_a: assert property ($fell(intrusion_pulse_n) |->
      $past(clr_wr, 2) || $past(clr_wr, 3)) else $error("intrusion pulse without write");
   rd_answer_a: assert property (reg_rd |=> reg_rd_valid) else $error("read not answered");
   valid_cause_a: assert property (reg_rd_valid |-> $past(reg_rd)) else $error("stray valid");
   rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("read data moved");
   status_read_a: assert property (reg_rd && reg_addr == `MMC_ADDR_STATUS1 |=>
      reg_rdata == {3'h0, $past(temp_status), 4'h0}) else $error("status byte wrong");
   fan_one_a: assert property (first_fan_ratio == 4'h1 << $past(first_fan_prescale))
      else $error("first ratio wrong");
   fan_two_a: assert property (second_fan_ratio == 4'h1 << $past(second_fan_prescale))
      else $error("second ratio wrong");
   status_cause_a: assert property ($rose(temp_status) |-> $past(conv_done))
      else $error("status set off a conversion");
   irq_cause_a: assert property (!temp_irq_n |-> temp_status && !$past(temp_irq_mask))
      else $error("interrupt without unmasked status");
   cover property ($fell(intrusion_pulse_n));
   cover property ($rose(temp_status));
   cover property ($rose(temp_irq_mask) && temp_status);
endmodule // mmc_regs_checker
bind mmc_regs mmc_regs_checker #(.CI_CYCLES(CI_CYCLES)) chk_i (
   .clk                 (clk),
   .rst_b               (rst_b),
   .reg_addr            (reg_addr),
   .reg_wr              (reg_wr),
   .reg_rd              (reg_rd),
   .reg_wdata           (reg_wdata),
   .reg_rdata           (reg_rdata),
   .reg_rd_valid        (reg_rd_valid),
   .conv_done           (conv_done),
   .temp_irq_mask       (temp_irq_mask),
   .temp_status         (temp_status),
   .temp_irq_n          (temp_irq_n),
   .intrusion_pulse_n   (intrusion_pulse_n),
   .first_fan_prescale  (first_fan_prescale),
   .second_fan_prescale (second_fan_prescale),
   .first_fan_ratio     (first_fan_ratio),
   .second_fan_ratio    (second_fan_ratio)
);

// *** dv/testbench.sv ***
// self-checking bench for the misc config register bank
`timescale 1ns/1ps
`include "mmc_consts.vh"
module testbench;
   localparam integer CI = 20;
   logic       clk = 0, rst_b = 0, conv_done = 0, temp_irq_mask = 0;
   logic       voltage_id_top_bit = 1, addr_select_pin_lo = 0, addr_select_pin_hi = 1;
   logic [3:0] voltage_id_bits = 4'hA;
   logic [8:0] temp_value = 9'h000;
   logic [7:0] hot_limit = 8'h32, hyst_limit = 8'h28;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic       reg_wr, reg_rd, reg_rd_valid, temp_status, temp_irq_n, intrusion_pulse_n;
   logic [1:0] first_fan_prescale, second_fan_prescale;
   logic [3:0] first_fan_ratio, second_fan_ratio;
   logic [6:0] bus_address;
   int         bad_count = 0, checks_done = 0;
   mmc_regs #(
      .CI_CYCLES (CI),
      .ID_RESET  (7'h2A)
   ) DUT (
      .clk                 (clk),
      .rst_b               (rst_b),
      .reg_addr            (reg_addr),
      .reg_wr              (reg_wr),
      .reg_rd              (reg_rd),
      .reg_wdata           (reg_wdata),
      .reg_rdata           (reg_rdata),
      .reg_rd_valid        (reg_rd_valid),
      .voltage_id_bits     (voltage_id_bits),
      .voltage_id_top_bit  (voltage_id_top_bit),
      .addr_select_pin_lo  (addr_select_pin_lo),
      .addr_select_pin_hi  (addr_select_pin_hi),
      .conv_done           (conv_done),
      .temp_value          (temp_value),
      .hot_limit           (hot_limit),
      .hyst_limit          (hyst_limit),
      .temp_irq_mask       (temp_irq_mask),
      .temp_status         (temp_status),
      .temp_irq_n          (temp_irq_n),
      .intrusion_pulse_n   (intrusion_pulse_n),
      .first_fan_prescale  (first_fan_prescale),
      .second_fan_prescale (second_fan_prescale),
      .first_fan_ratio     (first_fan_ratio),
      .second_fan_ratio    (second_fan_ratio),
      .bus_address         (bus_address)
   );
   mmc_host_model host (
      .clk          (clk),
      .reg_addr     (reg_addr),
      .reg_wr       (reg_wr),
      .reg_rd       (reg_rd),
      .reg_wdata    (reg_wdata),
      .reg_rdata    (reg_rdata),
      .reg_rd_valid (reg_rd_valid)
   );
   always #2.5 clk = ~clk;
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      bit to;
      host.rd(a, d, to);
      if (to) begin
         bad_count++;
         give_verdict();
      end else begin
         chk(d, exp);
      end
   endtask
   task automatic conv(input logic [7:0] t, input logic h);
      @(negedge clk);
      temp_value = {t, h};
      conv_done = 1'h1;
      @(negedge clk);
      conv_done = 1'h0;
      @(negedge clk);
   endtask
   task automatic st(input logic s, input logic n);
      chk({temp_status, temp_irq_n}, {s, n});
   endtask
   task automatic wait_pin(input logic lvl);
      int i;
      for (i = 0; i < 100 && intrusion_pulse_n !== lvl; i++) @(negedge clk);
      if (i == 100) begin
         bad_count++;
         give_verdict();
      end
   endtask
   task automatic t_reset;
      rdc(`MMC_ADDR_TEMP_CFG, 8'h01);
      rdc(`MMC_ADDR_COMPAT, 8'h00);
      rdc(`MMC_ADDR_INTR_CLR, 8'h00);
      rdc(`MMC_ADDR_VID_FAN, 8'h5A);
      rdc(`MMC_ADDR_BUS_ADDR, 8'h2E);
      chk(bus_address, 7'h2E);
      rdc(`MMC_ADDR_VID_IDENT, 8'h55);
      $display("reset test done");
   endtask
   task automatic t_regs;
      voltage_id_top_bit = 1'h0;
      for (int s = 0; s < 4; s++) begin
         host.wr(`MMC_ADDR_VID_FAN, {s[1:0], ~s[1:0], 4'h0});
         rdc(`MMC_ADDR_VID_FAN, {s[1:0], ~s[1:0], 4'hA});
         chk(second_fan_ratio, 4'h1 << s);
         chk(first_fan_ratio, 4'h1 << (3 - s));
         chk({second_fan_prescale, first_fan_prescale}, {s[1:0], ~s[1:0]});
      end
      host.wr(`MMC_ADDR_BUS_ADDR, 8'hFF);
      rdc(`MMC_ADDR_BUS_ADDR, 8'h7F);
      chk(bus_address, 7'h7F);
      host.wr(`MMC_ADDR_VID_IDENT, 8'hFF);
      rdc(`MMC_ADDR_VID_IDENT, 8'hFE);
      host.wr(`MMC_ADDR_COMPAT, 8'hA5);
      rdc(`MMC_ADDR_COMPAT, 8'hA5);
      host.wr(`MMC_ADDR_TEMP_CFG, 8'hFF);
      rdc(`MMC_ADDR_TEMP_CFG, 8'h7F);
      rdc(8'h4A, 8'h00);
      $display("register test done");
   endtask
   task automatic t_intr;
      int n;
      host.wr(`MMC_ADDR_INTR_CLR, 8'h80);
      wait_pin(1'h0);
      for (n = 0; n < 100 && intrusion_pulse_n === 1'h0; n++) @(negedge clk);
      if (n == 100) begin
         bad_count++;
         give_verdict();
      end else begin
         chk(n >= CI, 1);
      end
      rdc(`MMC_ADDR_INTR_CLR, 8'h00);
      host.wr(`MMC_ADDR_INTR_CLR, 8'h80);
      rdc(`MMC_ADDR_INTR_CLR, 8'h80);
      wait_pin(1'h1);
      rdc(`MMC_ADDR_INTR_CLR, 8'h00);
      $display("intrusion test done");
   endtask
   task automatic t_temp;
      conv(8'h3C, 1'h0);
      st(1'h1, 1'h0);
      rdc(`MMC_ADDR_STATUS1, 8'h10);
      st(1'h0, 1'h1);
      conv(8'h1E, 1'h0);
      host.wr(`MMC_ADDR_TEMP_CFG, 8'h00);
      conv(8'h3C, 1'h0);
      rdc(`MMC_ADDR_STATUS1, 8'h10);
      conv(8'h2D, 1'h0);
      st(1'h1, 1'h0);
      rdc(`MMC_ADDR_STATUS1, 8'h10);
      conv(8'h1E, 1'h0);
      conv(8'h2D, 1'h0);
      st(1'h0, 1'h1);
      host.wr(`MMC_ADDR_TEMP_CFG, 8'h01);
      conv(8'h3C, 1'h1);
      st(1'h1, 1'h0);
      rdc(`MMC_ADDR_TEMP_CFG, 8'h81);
      rdc(`MMC_ADDR_STATUS1, 8'h10);
      conv(8'h3C, 1'h0);
      st(1'h0, 1'h1);
      conv(8'h1E, 1'h0);
      conv(8'h3C, 1'h0);
      st(1'h1, 1'h0);
      host.wr(`MMC_ADDR_TEMP_CFG, 8'h02);
      rdc(`MMC_ADDR_STATUS1, 8'h10);
      st(1'h1, 1'h0);
      temp_irq_mask = 1'h1;
      repeat (2) @(negedge clk);
      st(1'h1, 1'h1);
      temp_irq_mask = 1'h0;
      conv(8'h2D, 1'h0);
      st(1'h0, 1'h1);
      $display("temperature test done");
   endtask
   task automatic t_seed;
      addr_select_pin_lo = 1'h1;
      addr_select_pin_hi = 1'h0;
      repeat (8) @(negedge clk);
      rst_b = 1'h0;
      repeat (4) @(negedge clk);
      chk({temp_status, temp_irq_n, intrusion_pulse_n}, 3'h3);
      chk(bus_address, 7'h2C);
      rst_b = 1'h1;
      repeat (12) @(negedge clk);
      chk(bus_address, 7'h2D);
      chk({first_fan_prescale, second_fan_prescale}, 4'h5);
      chk({first_fan_ratio, second_fan_ratio}, 8'h22);
      rdc(`MMC_ADDR_TEMP_CFG, 8'h01);
      rdc(`MMC_ADDR_VID_IDENT, 8'h54);
      $display("reset seed test done");
   endtask
   initial begin
      repeat (4) @(negedge clk);
      rst_b = 1'h1;
      repeat (12) @(negedge clk);
      t_reset();
      t_regs();
      t_intr();
      t_temp();
      t_seed();
      give_verdict();
   end
endmodule // testbench
